/* File: cpu_sfr_host.sv */
// cpu software model writing the serial mode register over the sfr strobes
// assumes the caller enters a task just after a rising clk edge
`timescale 1ns/100ps
module cpu_sfr_host (
    // clock
    input  wire logic                                 clk,
    // sfr write side
    output logic      [serial_mode_pkg::sfr_addr_width-1:0] sfr_addr,
    output logic                                      sfr_wr,
    output logic                                      sfr_bit_op,
    output logic      [2:0]                           sfr_bit_sel,
    output logic      [serial_mode_pkg::sfr_data_width-1:0] sfr_wdata
);
    import serial_mode_pkg::*;
    logic [7:0] shadow = serial_mode_control_reset;
    initial begin
        {sfr_addr, sfr_wr, sfr_bit_op, sfr_bit_sel, sfr_wdata} = '0;
    end
    // data bus shows the inverse once released, so a stale latch is caught
    task automatic put(input logic [15:0] a, input logic bo, input logic [2:0] s,
                       input logic [7:0] d);
        sfr_addr <= a; sfr_wr <= 1'b1; sfr_bit_op <= bo; sfr_bit_sel <= s; sfr_wdata <= d;
        @(posedge clk);
        sfr_wr <= 1'b0;
        sfr_wdata <= ~d;
        @(posedge clk);
    endtask
    task automatic mode_write(input logic [15:0] a, input logic [7:0] d);
        if (a == serial_mode_control_addr && !shadow[7] && d[6:5] != 2'b00) begin
            put(a, 1'b0, 3'h0, {1'b1, shadow[6:0]});
        end
        if (a == serial_mode_control_addr && shadow[7] && !d[7] && shadow[6:5] != 2'b00) begin
            put(a, 1'b0, 3'h0, {1'b1, 2'b00, shadow[4:0]});
        end
        put(a, 1'b0, 3'h0, d);
        if (a == serial_mode_control_addr) shadow = d;
    endtask
    task automatic bit_write(input logic [2:0] s, input logic v);
        put(serial_mode_control_addr, 1'b1, s, {{7{~v}}, v});
        shadow[s] = v;
    endtask
endmodule // cpu_sfr_host

/* File: serial_mode_control_unit.sv */
// mode register and enable/reset sequencing for the serial unit
// assumes cpu sfr write/read strobes on clk; datapath uses the enables and resets below
`timescale 1ns/100ps
module serial_mode_control_unit (
    // clock and reset
    input  wire logic                                       clk,
    input  wire logic                                       rst,
    // cpu sfr access
    input  wire logic [serial_mode_pkg::sfr_addr_width-1:0] sfr_addr,
    input  wire logic                                       sfr_wr,
    input  wire logic                                       sfr_bit_op,
    input  wire logic [2:0]                                 sfr_bit_sel,
    input  wire logic [serial_mode_pkg::sfr_data_width-1:0] sfr_wdata,
    output logic      [serial_mode_pkg::sfr_data_width-1:0] sfr_rdata,
    // datapath side
    input  wire logic                                       tx_data_from_core,
    input  wire logic                                       tx_busy,
    output logic                                            unit_clk_en,
    output logic                                            unit_async_rst,
    output logic                                            status_rst,
    output logic                                            tx_sync_rst,
    output logic                                            rx_sync_rst,
    output logic      [serial_mode_pkg::config_width-1:0]   serial_config,
    output logic                                            rx_data_to_core,
    output logic                                            port_mode,
    // pins
    input  wire logic                                       serial_in_pin,
    output logic                                            serial_out_pin
);
    import serial_mode_pkg::*;

    logic [7:0] serial_mode_control;
    logic [7:0] next_serial_mode_control;
    logic       out_level;
    logic       next_out_level;
    logic       rx_sync;
    logic       unit_power_enable;
    logic       transmit_enable_bit;
    logic       receive_enable_bit;
    logic [7:0] next_sfr_rdata;
    logic       next_rx_data;
    wire  [7:0] bit_hit;

    serial_pin_sync u_rx_sync (
        .clk   (clk),
        .rst   (rst),
        .pin   (serial_in_pin),
        .level (rx_sync)
    );

    assign unit_power_enable   = serial_mode_control[unit_power_enable_pos];
    assign transmit_enable_bit = serial_mode_control[transmit_enable_bit_pos];
    assign receive_enable_bit  = serial_mode_control[receive_enable_bit_pos];

    // one-hot decode of the bit index used by single-bit writes
    for (genvar g = 0; g < 8; g++) begin : g_bit_hit
        assign bit_hit[g] = (sfr_bit_sel == 3'(g));
    end

    // register write path, byte or single bit
    always_comb begin
        next_serial_mode_control = serial_mode_control;
        if (sfr_wr && sfr_addr == serial_mode_control_addr) begin
            if (sfr_bit_op) begin
                // read-modify-write of one bit; the other seven keep their value
                next_serial_mode_control = (serial_mode_control & ~bit_hit)
                                         | ({8{sfr_wdata[0]}} & bit_hit);
            end else begin
                next_serial_mode_control = sfr_wdata;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            serial_mode_control <= serial_mode_control_reset;
        end else begin
            serial_mode_control <= next_serial_mode_control;
        end
    end

    // read data leaves on a flop, one cycle after the address; unmapped reads give zero
    always_comb begin
        if (sfr_addr == serial_mode_control_addr) begin
            next_sfr_rdata = serial_mode_control;
        end else begin
            next_sfr_rdata = 8'h00;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata <= 8'h00;
        end else begin
            sfr_rdata <= next_sfr_rdata;
        end
    end

    // power gating and resets; datapath flops use unit_async_rst as an async clear
    assign unit_clk_en    = unit_power_enable;
    assign unit_async_rst = ~unit_power_enable;
    assign status_rst     = ~unit_power_enable;
    // relies on software order, but a dropped power bit still clears both paths
    assign tx_sync_rst    = ~transmit_enable_bit | ~unit_power_enable;
    assign rx_sync_rst    = ~receive_enable_bit | ~unit_power_enable;
    assign port_mode      = ~(unit_power_enable | transmit_enable_bit | receive_enable_bit);
    assign serial_config  = serial_mode_control[config_msb:0];

    // internal input forced high while powered down; a third flop after the
    // synchroniser keeps the core's view glitch-free when the power bit drops
    always_comb begin
        if (unit_power_enable) begin
            next_rx_data = rx_sync;
        end else begin
            next_rx_data = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rx_data_to_core <= 1'b1;
        end else begin
            rx_data_to_core <= next_rx_data;
        end
    end

    // registered line level; idle high outside transmission
    always_comb begin
        if (unit_power_enable && transmit_enable_bit) begin
            next_out_level = tx_data_from_core;
        end else begin
            next_out_level = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_level <= 1'b1;
        end else begin
            out_level <= next_out_level;
        end
    end

    assign serial_out_pin = out_level;

    // power-down and power-on behaviour
    a_power_off_line: assert property (@(posedge clk) disable iff (rst)
        !unit_power_enable |=> serial_out_pin)
        else $error("output line not high after power off");
    a_busy_power_off: assert property (@(posedge clk) disable iff (rst)
        tx_busy && !unit_power_enable |=> serial_out_pin)
        else $error("line not high when power dropped during transmission");
    a_power_off_rx: assert property (@(posedge clk) disable iff (rst)
        !unit_power_enable |=> rx_data_to_core)
        else $error("internal input not forced high after power off");
    a_power_off_unit: assert property (@(posedge clk) disable iff (rst)
        !unit_power_enable |-> unit_async_rst && !unit_clk_en)
        else $error("power off did not stop clock or reset unit");
    a_power_on_unit: assert property (@(posedge clk) disable iff (rst)
        unit_power_enable |-> unit_clk_en && !unit_async_rst && !status_rst)
        else $error("unit held in reset while powered");
    a_status_reset: assert property (@(posedge clk) disable iff (rst)
        !unit_power_enable |-> status_rst)
        else $error("status registers not reset with power off");

    // enables, line and stop mode
    a_tx_reset: assert property (@(posedge clk) disable iff (rst)
        !transmit_enable_bit |-> tx_sync_rst ##1 serial_out_pin)
        else $error("transmit not reset when disabled");
    a_rx_reset: assert property (@(posedge clk) disable iff (rst)
        !receive_enable_bit |-> rx_sync_rst)
        else $error("receive not reset when disabled");
    a_line_follow: assert property (@(posedge clk) disable iff (rst)
        unit_power_enable && transmit_enable_bit |=> serial_out_pin == $past(tx_data_from_core))
        else $error("output line does not follow transmit data");
    a_rx_follow: assert property (@(posedge clk) disable iff (rst)
        unit_power_enable |=> rx_data_to_core == $past(rx_sync))
        else $error("internal input does not follow pin while powered");
    a_stop_mode: assert property (@(posedge clk) disable iff (rst)
        port_mode == (serial_mode_control[7:5] == 3'b000))
        else $error("stop mode mismatch");

    // register access
    a_byte_write: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && !sfr_bit_op && sfr_addr == serial_mode_control_addr
        |=> serial_mode_control == $past(sfr_wdata))
        else $error("byte write not stored");
    a_bit_write: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && sfr_bit_op && sfr_addr == serial_mode_control_addr
        |=> serial_mode_control[$past(sfr_bit_sel)] == $past(sfr_wdata[0]))
        else $error("bit write not stored");
    a_bit_others: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && sfr_bit_op && sfr_addr == serial_mode_control_addr
        |=> ((serial_mode_control ^ $past(serial_mode_control))
             & ~(8'h01 << $past(sfr_bit_sel))) == 8'h00)
        else $error("bit write disturbed other bits");
    a_config_pass: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && !sfr_bit_op && sfr_addr == serial_mode_control_addr
        |=> serial_config == $past(sfr_wdata[4:0]))
        else $error("config bits not passed through");
    a_other_addr: assert property (@(posedge clk) disable iff (rst)
        sfr_wr && sfr_addr != serial_mode_control_addr |=> $stable(serial_mode_control))
        else $error("write to other address changed mode register");
    a_hold_no_write: assert property (@(posedge clk) disable iff (rst)
        !sfr_wr |=> $stable(serial_mode_control))
        else $error("mode register changed without a write");
    a_read_data: assert property (@(posedge clk) disable iff (rst)
        sfr_addr == serial_mode_control_addr |=> sfr_rdata == $past(serial_mode_control))
        else $error("read data does not show mode register");
    a_read_unmapped: assert property (@(posedge clk) disable iff (rst)
        sfr_addr != serial_mode_control_addr |=> sfr_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule // serial_mode_control_unit

/* File: serial_mode_pkg.sv */
// constants for the serial mode-control block
// assumes an 8-bit special-function register space with 16-bit addresses
package serial_mode_pkg;
    localparam logic [15:0] serial_mode_control_addr  = 16'hff50;
    localparam logic [7:0]  serial_mode_control_reset = 8'h01;
    localparam int          unit_power_enable_pos     = 7;
    localparam int          transmit_enable_bit_pos   = 6;
    localparam int          receive_enable_bit_pos    = 5;
    localparam int          config_msb                = 4;
    localparam int          config_width              = 5;
    localparam int          sfr_addr_width            = 16;
    localparam int          sfr_data_width            = 8;
endpackage

/* File: serial_pin_sync.sv */
// two-stage synchroniser for the serial input pin
// assumes the pin is asynchronous to clk
`timescale 1ns/100ps
module serial_pin_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // pin and synchronised level
    input  wire logic pin,
    output logic      level
);
    logic meta;
    logic next_meta;
    logic next_level;

    always_comb begin
        next_meta  = pin;
        next_level = meta;
    end

    // idle line is high, so reset to high
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta  <= 1'b1;
            level <= 1'b1;
        end else begin
            meta  <= next_meta;
            level <= next_level;
        end
    end
endmodule // serial_pin_sync

/* File: uart_operation_mode_control_tb_top.sv */
// self-checking bench for the serial mode-control unit
// assumes cpu_sfr_host orders enable and power writes legally
`timescale 1ns/100ps
module uart_operation_mode_control_tb_top;
    import serial_mode_pkg::*;
    logic        clk = 1'b0, rst = 1'b1, txd = 1'b0, pin = 1'b1, busy = 1'b0;
    logic [15:0] a;
    logic [7:0]  wd, rd, m;
    logic [2:0]  bs;
    logic [4:0]  cfg;
    logic        wr, bo, ce, ar, sr, tr, rr, rxc, pm, so;
    integer      failures = 0, tests_run = 0, seed = 32'hab1a4dae, r, i;
    initial begin
        forever #2 clk = ~clk;
    end
    cpu_sfr_host cpu_sfr_host_i (.clk(clk), .sfr_addr(a), .sfr_wr(wr), .sfr_bit_op(bo),
        .sfr_bit_sel(bs), .sfr_wdata(wd));
    serial_mode_control_unit serial_mode_control_unit_i (.clk(clk), .rst(rst), .sfr_addr(a),
        .sfr_wr(wr), .sfr_bit_op(bo), .sfr_bit_sel(bs), .sfr_wdata(wd), .sfr_rdata(rd),
        .tx_data_from_core(txd), .tx_busy(busy), .unit_clk_en(ce), .unit_async_rst(ar),
        .status_rst(sr), .tx_sync_rst(tr), .rx_sync_rst(rr), .serial_config(cfg),
        .rx_data_to_core(rxc), .port_mode(pm), .serial_in_pin(pin), .serial_out_pin(so));
    task automatic complete_run();
        $display("failures %0d tests_run %0d", failures, tests_run);
        if (failures == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // one compare task per kind of result: read data, unit controls, line levels
    task automatic chk_read(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t read data %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_ctrl(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t control outputs %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_line(input logic [1:0] got, input logic [1:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t line levels %b expected %b", $time, got, exp);
        end
    endtask
    task automatic check_all();
        chk_read(rd, (a == serial_mode_control_addr) ? m : 8'h00);
        chk_ctrl({6'h0, ce, ar}, {6'h0, m[7], !m[7]});
        chk_ctrl({7'h0, sr}, {7'h0, !m[7]});
        chk_ctrl({7'h0, tr}, {7'h0, !(m[7] && m[6])});
        chk_ctrl({7'h0, rr}, {7'h0, !(m[7] && m[5])});
        chk_ctrl({7'h0, pm}, {7'h0, m[7:5] == 3'b000});
        chk_ctrl({3'h0, cfg}, {3'h0, m[4:0]});
        chk_line({so, rxc}, {(m[7] && m[6]) ? txd : 1'b1, m[7] ? pin : 1'b1});
    endtask
    // one register write, then three cycles so the output flop has followed
    task automatic step(input logic [15:0] ad, input logic [7:0] d, input logic bm,
                        input logic [2:0] s);
        @(posedge clk);
        r = $random(seed);
        txd <= r[0];
        pin <= r[1];
        busy <= r[2];
        if (bm) begin
            cpu_sfr_host_i.bit_write(s, d[0]);
            m[s] = d[0];
        end else begin
            cpu_sfr_host_i.mode_write(ad, d);
            if (ad == serial_mode_control_addr) m = d;
        end
        repeat (3) @(posedge clk);
        #1 check_all();
    endtask
    initial begin
        m = serial_mode_control_reset;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check_all();
        step(serial_mode_control_addr, 8'he3, 1'b0, 3'h0);
        step(serial_mode_control_addr, 8'h00, 1'b1, 3'h6);
        step(serial_mode_control_addr, 8'h00, 1'b1, 3'h5);
        step(serial_mode_control_addr, 8'h00, 1'b1, 3'h7);
        step(16'hff51, 8'hff, 1'b0, 3'h0);
        for (i = 0; i < 16; i++) begin
            r = $random(seed);
            step(serial_mode_control_addr, r[7] ? r[7:0] : {3'b000, r[4:0]}, 1'b0, 3'h0);
        end
        // reset in mid-run brings the register back to its reset value
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        m = serial_mode_control_reset;
        cpu_sfr_host_i.shadow = serial_mode_control_reset;
        repeat (2) @(posedge clk);
        #1 check_all();
        // bit writes that set power first, then transmit, then a config bit
        step(serial_mode_control_addr, 8'h01, 1'b1, 3'h7);
        step(serial_mode_control_addr, 8'h01, 1'b1, 3'h6);
        step(serial_mode_control_addr, 8'h01, 1'b1, 3'h3);
        complete_run();
    end
    initial begin
        #20000;
        failures++;
        complete_run();
    end
endmodule // uart_operation_mode_control_tb_top
